// File: irpe_engine.sv
// IR remote pattern engine top: registers, pattern and duration RAMs, sequencer.
// Assumes a byte register port behind the serial host link, one write per pulse.
//
// Notes on behaviour
// - Byte 0xFF ends the current pass
// - Byte 0xFE loads next byte as repeat start
// - Operator bytes never index the duration table
// - Upper nibble pulse, lower nibble gap
// - Sixteen 16-bit durations in carrier periods
// - Zero duration keeps previous LED state
// - Duration low byte even, high byte odd
// - Duration table only visible in bank one
// - Carrier period is setting times 250 ns, settings below 8 taken as 8
// - DC select drives steady level in pulses
// - Duty select picks 50/37/25/12 percent
// - Complete patterns separated by pause x 10us
// - Output select routes to LED or GPIO
// - Inversion flips both LED and GPIO
// - Drive field sets LED current during pulse
// - Burst end sets flag in both status registers
// - Interrupt pin only when enable bit or force bit set
// - Force bit raises flags and pin
// - Busy while transmitting, clear when idle
// - Complete pattern starts at address zero
// - Full loop count adds passes; 0xFF forever
// - Sub loop count adds repeats; 0xFF forever
// - Engine runs only while enable bit set
// - Pattern RAM 256 bytes in two banks
`timescale 1ns/1ps
`include "irpe_consts.svh"
module irpe_engine (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  output logic [7:0] reg_rdata,
  output logic led_sink_pin,
  output logic [4:0] led_drive_level,
  output logic gpio_out,
  output logic gpio_oe,
  output logic int_n,
  output logic sensor_hold
);
  irpe_if lnk ();
  irpe_pkg::irpe_eng_t s;
  irpe_pkg::irpe_eng_t n;
  logic [7:0] pattern [0:255];
  logic [7:0] tw_bytes [0:31];
  logic [7:0] cur_byte;
  logic [7:0] next_byte;
  logic start_req;
  logic clear_req;
  logic engine_en;
  logic busy;
  logic wave;
  logic led_sel;
  logic gpio_sel;
  logic invert;
  logic sub_again;
  logic full_again;
  logic pause_go;
  logic [7:0] pause_len;
  logic pulse_cut;

  function automatic logic [15:0] tw_word(input logic [3:0] idx);
    tw_word = {tw_bytes[{idx, 1'b1}], tw_bytes[{idx, 1'b0}]};
  endfunction

  irpe_carrier u_carrier (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .cif(lnk.carrier)
  );

  irpe_pause u_pause (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pif(lnk.pause)
  );

  // Host side of both RAMs; no reset on storage
  always_ff @(posedge clk_sys) begin
    if (reg_wr && reg_addr < `IRPE_RAM_TOP) begin
      if (!s.bank) begin
        pattern[{1'b0, reg_addr[6:0]}] <= reg_wdata;
      end else if (reg_addr < `IRPE_TW_TOP) begin
        tw_bytes[reg_addr[4:0]] <= reg_wdata;
      end else begin
        pattern[{1'b1, reg_addr[6:0]}] <= reg_wdata;
      end
    end
  end

  always_comb begin
    cur_byte = pattern[s.ptr];
    next_byte = pattern[8'(s.ptr + 8'h01)];
    engine_en = s.enable[`IRPE_BIT_ENGINE_EN];
    busy = (s.state != irpe_pkg::IRPE_IDLE);
    start_req = reg_wr && reg_addr == `IRPE_OFF_START && reg_wdata[`IRPE_BIT_START];
    clear_req = reg_wr && reg_addr == `IRPE_OFF_INTCLR && !reg_wdata[`IRPE_BIT_INTCLR];
    sub_again = s.has_rep && (s.subloop == `IRPE_LOOP_FOREVER
      || (s.sub_left != 8'h00 && s.sub_left != `IRPE_LOOP_FOREVER));
    full_again = s.fullloop == `IRPE_LOOP_FOREVER
      || (s.full_left != 8'h00 && s.full_left != `IRPE_LOOP_FOREVER);
    // Mask the carrier period that opens at the last tick of a pulse
    pulse_cut = s.state == irpe_pkg::IRPE_PULSE && lnk.car_tick && s.cnt == 16'h0001
      && tw_word(s.gap_idx) != 16'h0000;
    pause_go = 1'b0;
    pause_len = 8'h00;
    n = s;
    if (reg_wr) begin
      unique case (reg_addr)
        `IRPE_OFF_ENABLE: n.enable = reg_wdata;
        `IRPE_OFF_BANK: n.bank = reg_wdata[`IRPE_BIT_BANK];
        `IRPE_OFF_DRIVE: n.drive = reg_wdata[4:0];
        `IRPE_OFF_CONFIG: n.config_r = reg_wdata;
        `IRPE_OFF_OUTCFG: n.outcfg = reg_wdata[5:0];
        `IRPE_OFF_SUBLOOP: n.subloop = reg_wdata;
        `IRPE_OFF_SUBPAUSE: n.subpause = reg_wdata;
        `IRPE_OFF_FULLLOOP: n.fullloop = reg_wdata;
        `IRPE_OFF_FULLPAUSE: n.fullpause = reg_wdata;
        `IRPE_OFF_CARRIER: n.carrier = reg_wdata;
        default: n.enable = s.enable;
      endcase
    end
    unique case (s.state)
      irpe_pkg::IRPE_IDLE: begin
        n.mod_on = 1'b0;
        if (start_req && engine_en) begin
          n.state = irpe_pkg::IRPE_FETCH;
          n.ptr = 8'h00;
          n.has_rep = 1'b0;
          n.sub_left = s.subloop;
          n.full_left = s.fullloop;
        end
      end
      irpe_pkg::IRPE_FETCH: begin
        if (cur_byte == `IRPE_OP_STOP) begin
          n.mod_on = 1'b0;
          if (sub_again) begin
            if (s.subloop != `IRPE_LOOP_FOREVER) begin
              n.sub_left = s.sub_left - 8'h01;
            end
            n.ptr = s.rep_dest;
            pause_go = 1'b1;
            pause_len = s.subpause;
            n.state = irpe_pkg::IRPE_PAUSE_SUB;
          end else if (full_again) begin
            if (s.fullloop != `IRPE_LOOP_FOREVER) begin
              n.full_left = s.full_left - 8'h01;
            end
            n.ptr = 8'h00;
            n.has_rep = 1'b0;
            n.sub_left = s.subloop;
            pause_go = 1'b1;
            pause_len = s.fullpause;
            n.state = irpe_pkg::IRPE_PAUSE_FULL;
          end else begin
            n.state = irpe_pkg::IRPE_DONE;
          end
        end else if (cur_byte == `IRPE_OP_REPEAT) begin
          n.rep_dest = next_byte;
          n.has_rep = 1'b1;
          n.ptr = 8'(s.ptr + 8'h02);
        end else begin
          n.ptr = 8'(s.ptr + 8'h01);
          n.gap_idx = cur_byte[3:0];
          if (tw_word(cur_byte[7:4]) != 16'h0000) begin
            n.cnt = tw_word(cur_byte[7:4]);
            n.mod_on = 1'b1;
            n.state = irpe_pkg::IRPE_PULSE;
          end else begin
            n.state = irpe_pkg::IRPE_GAP_LOAD;
          end
        end
      end
      irpe_pkg::IRPE_PULSE: begin
        if (lnk.car_tick) begin
          n.cnt = s.cnt - 16'h0001;
          if (s.cnt == 16'h0001) begin
            n.state = irpe_pkg::IRPE_GAP_LOAD;
            n.mod_on = !pulse_cut;
          end
        end
      end
      irpe_pkg::IRPE_GAP_LOAD: begin
        if (tw_word(s.gap_idx) != 16'h0000) begin
          n.cnt = tw_word(s.gap_idx);
          n.mod_on = 1'b0;
          n.state = irpe_pkg::IRPE_GAP;
        end else begin
          n.state = irpe_pkg::IRPE_FETCH;
        end
      end
      irpe_pkg::IRPE_GAP: begin
        if (lnk.car_tick) begin
          n.cnt = s.cnt - 16'h0001;
          if (s.cnt == 16'h0001) begin
            n.state = irpe_pkg::IRPE_FETCH;
          end
        end
      end
      irpe_pkg::IRPE_PAUSE_SUB, irpe_pkg::IRPE_PAUSE_FULL: begin
        if (lnk.pause_done) begin
          n.state = irpe_pkg::IRPE_FETCH;
        end
      end
      irpe_pkg::IRPE_DONE: begin
        n.state = irpe_pkg::IRPE_IDLE;
      end
    endcase
    if (!engine_en) begin
      n.state = irpe_pkg::IRPE_IDLE;
      n.mod_on = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (s.state == irpe_pkg::IRPE_DONE || s.config_r[`IRPE_BIT_INT_FORCE]) begin
      n.iint = 1'b1;
    end else if (clear_req) begin
      n.iint = 1'b0;
    end
    invert = s.outcfg[`IRPE_BIT_INVERT];
    led_sel = s.outcfg[`IRPE_BIT_OSEL_HI:`IRPE_BIT_OSEL_LO] == `IRPE_OSEL_LED;
    gpio_sel = s.outcfg[`IRPE_BIT_OSEL_HI:`IRPE_BIT_OSEL_LO] == `IRPE_OSEL_GPIO;
    wave = busy && s.mod_on && !pulse_cut && (s.outcfg[`IRPE_BIT_DC] || lnk.car_level);
    n.led_out = (engine_en && led_sel && wave) ^ invert;
    n.led_level = (engine_en && led_sel && wave) ? s.drive : 5'h00;
    n.gpio_out = (gpio_sel && wave) ^ invert;
    n.gpio_oe = engine_en && gpio_sel;
    n.int_n = !((n.iint && s.config_r[`IRPE_BIT_INT_EN])
      || s.config_r[`IRPE_BIT_INT_FORCE]);
    if (reg_addr < `IRPE_RAM_TOP) begin
      if (!s.bank) begin
        n.rdata = pattern[{1'b0, reg_addr[6:0]}];
      end else if (reg_addr < `IRPE_TW_TOP) begin
        n.rdata = tw_bytes[reg_addr[4:0]];
      end else begin
        n.rdata = pattern[{1'b1, reg_addr[6:0]}];
      end
    end else begin
      unique case (reg_addr)
        `IRPE_OFF_ENABLE: n.rdata = s.enable;
        `IRPE_OFF_BANK: n.rdata = {7'h00, s.bank};
        `IRPE_OFF_DRIVE: n.rdata = {3'h0, s.drive};
        `IRPE_OFF_STATUS: n.rdata = 8'(s.iint) << `IRPE_BIT_STATUS_INT;
        `IRPE_OFF_CONFIG: n.rdata = s.config_r;
        `IRPE_OFF_OUTCFG: n.rdata = {2'h0, s.outcfg};
        `IRPE_OFF_SUBLOOP: n.rdata = s.subloop;
        `IRPE_OFF_SUBPAUSE: n.rdata = s.subpause;
        `IRPE_OFF_FULLLOOP: n.rdata = s.fullloop;
        `IRPE_OFF_FULLPAUSE: n.rdata = s.fullpause;
        `IRPE_OFF_CARRIER: n.rdata = s.carrier;
        `IRPE_OFF_BSTATUS: n.rdata = {6'h00, s.iint, busy};
        default: n.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.int_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign lnk.car_setting = s.carrier;
  assign lnk.car_duty = s.outcfg[1:0];
  assign lnk.car_run = busy;
  assign lnk.pause_go = pause_go;
  assign lnk.pause_len = pause_len;
  assign reg_rdata = s.rdata;
  assign led_sink_pin = s.led_out;
  assign led_drive_level = s.led_level;
  assign gpio_out = s.gpio_out;
  assign gpio_oe = s.gpio_oe;
  assign int_n = s.int_n;
  assign sensor_hold = engine_en;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_stop_no_pulse: assert property (s.state == irpe_pkg::IRPE_FETCH
    && cur_byte == `IRPE_OP_STOP |=> s.state != irpe_pkg::IRPE_PULSE
    && s.state != irpe_pkg::IRPE_GAP_LOAD)
    else $error("stop byte did not end the pass");
  a_repeat_dest_load: assert property (s.state == irpe_pkg::IRPE_FETCH
    && cur_byte == `IRPE_OP_REPEAT && engine_en
    |=> s.rep_dest == $past(next_byte) && s.ptr == 8'($past(s.ptr) + 8'h02))
    else $error("repeat destination not taken");
  a_ops_not_indexed: assert property (s.state == irpe_pkg::IRPE_FETCH
    && cur_byte >= `IRPE_OP_REPEAT |=> s.cnt == $past(s.cnt))
    else $error("operator byte loaded a duration");
  a_pulse_load: assert property (s.state == irpe_pkg::IRPE_FETCH && engine_en
    && cur_byte < `IRPE_OP_REPEAT && tw_word(cur_byte[7:4]) != 16'h0000
    |=> s.state == irpe_pkg::IRPE_PULSE && s.cnt == $past(tw_word(cur_byte[7:4]))
    && s.gap_idx == $past(cur_byte[3:0]))
    else $error("pulse duration not loaded from upper nibble");
  a_zero_keeps_led: assert property (s.state == irpe_pkg::IRPE_GAP_LOAD
    && tw_word(s.gap_idx) == 16'h0000 && engine_en |=> s.mod_on == $past(s.mod_on))
    else $error("zero duration changed LED state");
  a_done_sets_flag: assert property (s.state == irpe_pkg::IRPE_DONE
    |=> s.iint ##1 (reg_rdata[`IRPE_BIT_STATUS_INT] || $past(reg_addr) != `IRPE_OFF_STATUS))
    else $error("burst end did not set flag");
  a_int_pin_gate: assert property (!s.config_r[`IRPE_BIT_INT_EN]
    && !s.config_r[`IRPE_BIT_INT_FORCE] && !$past(s.config_r[`IRPE_BIT_INT_FORCE]) |=> int_n)
    else $error("interrupt pin active while disabled");
  a_force_raises: assert property (s.config_r[`IRPE_BIT_INT_FORCE]
    |=> s.iint && !int_n)
    else $error("force did not raise flag and pin");
  a_start_gated: assert property (s.state == irpe_pkg::IRPE_IDLE
    && start_req && !engine_en |=> s.state == irpe_pkg::IRPE_IDLE)
    else $error("burst started while disabled");
  a_disable_idles: assert property (!engine_en |=> !busy ##1 !wave)
    else $error("engine kept running after disable");
  a_full_restart: assert property (s.state == irpe_pkg::IRPE_PAUSE_FULL
    |-> s.ptr == 8'h00 && !s.has_rep)
    else $error("complete pattern not restarted at zero");
  a_idle_outputs: assert property (!busy[*2] |=> led_sink_pin == $past(invert)
    && led_drive_level == 5'h00)
    else $error("idle output not at inactive level");
  a_int_pin_on: assert property (s.state == irpe_pkg::IRPE_DONE
    && s.config_r[`IRPE_BIT_INT_EN] |=> !int_n)
    else $error("interrupt pin not raised at burst end");
  a_sub_pause_go: assert property (s.state == irpe_pkg::IRPE_FETCH
    && cur_byte == `IRPE_OP_STOP && sub_again && engine_en |=> s.state == irpe_pkg::IRPE_PAUSE_SUB)
    else $error("sub-pattern repeat skipped its pause");

  c_burst_done: cover property (s.state == irpe_pkg::IRPE_DONE);
  c_repeat_op: cover property (s.state == irpe_pkg::IRPE_FETCH && cur_byte == `IRPE_OP_REPEAT);
  c_sub_pause: cover property (s.state == irpe_pkg::IRPE_PAUSE_SUB && lnk.pause_done);
  c_zero_carry: cover property (s.state == irpe_pkg::IRPE_GAP_LOAD && tw_word(s.gap_idx) == 16'h0000);
  c_full_pause: cover property (s.state == irpe_pkg::IRPE_PAUSE_FULL);
endmodule // irpe_engine

// File: irpe_consts.svh
// Constants of the IR remote pattern engine: offsets, fields, resets, timing.
// Included by bare name from every design file that needs a number.
`ifndef IRPE_CONSTS_SVH
`define IRPE_CONSTS_SVH
// Register offsets
`define IRPE_OFF_ENABLE 8'h80
`define IRPE_OFF_BANK 8'h8D
`define IRPE_OFF_DRIVE 8'h8F
`define IRPE_OFF_STATUS 8'h93
`define IRPE_OFF_CONFIG 8'hA0
`define IRPE_OFF_OUTCFG 8'hA1
`define IRPE_OFF_SUBLOOP 8'hA2
`define IRPE_OFF_SUBPAUSE 8'hA3
`define IRPE_OFF_FULLLOOP 8'hA4
`define IRPE_OFF_FULLPAUSE 8'hA5
`define IRPE_OFF_CARRIER 8'hA6
`define IRPE_OFF_BSTATUS 8'hA8
`define IRPE_OFF_START 8'hA9
`define IRPE_OFF_INTCLR 8'hDE
// Field positions
`define IRPE_BIT_ENGINE_EN 7
`define IRPE_BIT_BANK 0
`define IRPE_BIT_STATUS_INT 3
`define IRPE_BIT_INT_EN 5
`define IRPE_BIT_INT_FORCE 6
`define IRPE_BIT_INVERT 5
`define IRPE_BIT_OSEL_HI 4
`define IRPE_BIT_OSEL_LO 3
`define IRPE_BIT_DC 2
`define IRPE_BIT_BSTAT_INT 1
`define IRPE_BIT_BSTAT_BUSY 0
`define IRPE_BIT_START 1
`define IRPE_BIT_INTCLR 3
// Encodings and reset values
`define IRPE_OSEL_LED 2'h0
`define IRPE_OSEL_GPIO 2'h1
`define IRPE_OP_STOP 8'hFF
`define IRPE_OP_REPEAT 8'hFE
`define IRPE_LOOP_FOREVER 8'hFF
`define IRPE_RAM_TOP 8'h80
`define IRPE_TW_TOP 8'h20
`define IRPE_RESET_BYTE 8'h00
`define IRPE_MIN_CARRIER 8'h08
// Timing
`define IRPE_CLK_NS 32'h00000028
`define IRPE_CAR_STEP_NS 32'h000000FA
`define IRPE_PAUSE_UNIT_NS 32'h00002710
`define IRPE_PAUSE_CYCLES (`IRPE_PAUSE_UNIT_NS / `IRPE_CLK_NS)
`endif

// File: irpe_pkg.sv
// Types of the IR remote pattern engine: engine states and state records.
// Assumes irpe_consts.svh supplies all numbers.
package irpe_pkg;
  typedef enum logic [3:0] {
    IRPE_IDLE, IRPE_FETCH, IRPE_PULSE, IRPE_GAP_LOAD, IRPE_GAP,
    IRPE_PAUSE_SUB, IRPE_PAUSE_FULL, IRPE_DONE
  } irpe_state_t;

  typedef struct packed {
    irpe_state_t state;
    logic [7:0] enable;
    logic bank;
    logic [4:0] drive;
    logic [7:0] config_r;
    logic [5:0] outcfg;
    logic [7:0] subloop;
    logic [7:0] subpause;
    logic [7:0] fullloop;
    logic [7:0] fullpause;
    logic [7:0] carrier;
    logic iint;
    logic [7:0] ptr;
    logic [7:0] rep_dest;
    logic has_rep;
    logic [7:0] sub_left;
    logic [7:0] full_left;
    logic [15:0] cnt;
    logic [3:0] gap_idx;
    logic mod_on;
    logic led_out;
    logic [4:0] led_level;
    logic gpio_out;
    logic gpio_oe;
    logic int_n;
    logic [7:0] rdata;
  } irpe_eng_t;

  typedef struct packed {
    logic [15:0] phase;
    logic level;
    logic tick;
  } irpe_car_t;

  typedef struct packed {
    logic [7:0] sub;
    logic [7:0] units;
    logic active;
    logic done;
  } irpe_pause_t;
endpackage

// File: irpe_if.sv
// Carrier and pause links between the engine and its two helpers.
// Assumes all three sit on the same clock.
`timescale 1ns/1ps
interface irpe_if;
  logic [7:0] car_setting;
  logic [1:0] car_duty;
  logic car_run;
  logic car_level;
  logic car_tick;
  logic pause_go;
  logic [7:0] pause_len;
  logic pause_done;
  modport engine (
    output car_setting, car_duty, car_run, pause_go, pause_len,
    input car_level, car_tick, pause_done
  );
  modport carrier (input car_setting, car_duty, car_run, output car_level, car_tick);
  modport pause (input pause_go, pause_len, output pause_done);
endinterface

// File: irpe_carrier.sv
// Carrier generator: period of setting x 250 ns with settings below 8 taken as 8, duty from a 2-bit select.
// Assumes clk_sys at 40 ns; phase kept in ns so 250 ns steps stay exact on average.
`timescale 1ns/1ps
`include "irpe_consts.svh"
module irpe_carrier (
  input wire logic clk_sys,
  input wire logic rstn,
  irpe_if.carrier cif
);
  irpe_pkg::irpe_car_t s;
  irpe_pkg::irpe_car_t n;
  logic [7:0] setting;
  logic [15:0] per_ns;
  logic [17:0] high_ns;
  logic [16:0] sum;

  always_comb begin
    setting = (cif.car_setting < `IRPE_MIN_CARRIER) ? `IRPE_MIN_CARRIER : cif.car_setting;
    per_ns = 16'(setting * `IRPE_CAR_STEP_NS);
    unique case (cif.car_duty)
      2'h0: high_ns = {3'h0, per_ns[15:1]};
      2'h1: high_ns = 18'({2'h0, per_ns} * 18'h00003) >> 3;
      2'h2: high_ns = {4'h0, per_ns[15:2]};
      2'h3: high_ns = {5'h00, per_ns[15:3]};
    endcase
    sum = {1'h0, s.phase} + 17'(`IRPE_CLK_NS);
    n = s;
    n.tick = 1'b0;
    if (!cif.car_run) begin
      n.phase = 16'h0000;
    end else if (sum >= {1'h0, per_ns}) begin
      n.phase = 16'(sum - {1'h0, per_ns});
      n.tick = 1'b1;
    end else begin
      n.phase = sum[15:0];
    end
    n.level = cif.car_run && ({2'h0, n.phase} < high_ns);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign cif.car_level = s.level;
  assign cif.car_tick = s.tick;
endmodule // irpe_carrier

// File: irpe_pause.sv
// Pause timer: one done pulse after length x 10 us; length 0 ends at once.
// Assumes a one-cycle go pulse from the engine, which then waits for done.
`timescale 1ns/1ps
`include "irpe_consts.svh"
module irpe_pause (
  input wire logic clk_sys,
  input wire logic rstn,
  irpe_if.pause pif
);
  localparam logic [7:0] UNIT_LAST = 8'(`IRPE_PAUSE_CYCLES - 1);
  irpe_pkg::irpe_pause_t s;
  irpe_pkg::irpe_pause_t n;

  always_comb begin
    n = s;
    n.done = 1'b0;
    if (pif.pause_go) begin
      n.units = pif.pause_len;
      n.sub = 8'h00;
      n.active = (pif.pause_len != 8'h00);
      n.done = (pif.pause_len == 8'h00);
    end else if (s.active) begin
      if (s.sub == UNIT_LAST) begin
        n.sub = 8'h00;
        n.units = s.units - 8'h01;
        if (s.units == 8'h01) begin
          n.active = 1'b0;
          n.done = 1'b1;
        end
      end else begin
        n.sub = s.sub + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign pif.pause_done = s.done;
endmodule // irpe_pause

// File: irpe_led_rx.sv
// Receiver model for the IR engine outputs: counts carrier edges and times the waveform.
// Assumes it samples the LED and GPIO lines on the system clock edge.
`timescale 1ns/1ps
module irpe_led_rx (
  input wire logic clk_sys,
  input wire logic led_sink_pin,
  input wire logic [4:0] led_drive_level,
  input wire logic gpio_out
);
  int edges = 0;
  int gedges = 0;
  int period = 0;
  int high = 0;
  int run = 0;
  int hrun = 0;
  logic [4:0] level = 5'h00;
  logic led_q = 1'b0;
  logic gpio_q = 1'b0;
  // Rising edges, carrier period, high time and drive level at each rise
  always @(posedge clk_sys) begin
    run <= run + 1;
    hrun <= led_sink_pin ? hrun + 1 : 0;
    if (led_sink_pin && !led_q) begin
      edges <= edges + 1;
      period <= run + 1;
      run <= 0;
      level <= led_drive_level;
    end
    if (!led_sink_pin && led_q) begin
      high <= hrun;
    end
    if (gpio_out && !gpio_q) begin
      gedges <= gedges + 1;
    end
    led_q <= led_sink_pin;
    gpio_q <= gpio_out;
  end
endmodule // irpe_led_rx

// File: tb_top.sv
// Testbench of the IR pattern engine: register tasks, bursts and output checks.
// Assumes the engine top and the receiver model; carrier setting 32 gives 200 cycles.
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_rdata;
  logic led_sink_pin;
  logic [4:0] led_drive_level;
  logic gpio_out;
  logic gpio_oe;
  logic int_n;
  logic sensor_hold;
  int num_errors = 0;
  int checked = 0;
  irpe_engine u_irpe_engine (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
    .led_sink_pin(led_sink_pin), .led_drive_level(led_drive_level), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .int_n(int_n), .sensor_hold(sensor_hold));
  irpe_led_rx u_irpe_led_rx (.clk_sys(clk_sys), .led_sink_pin(led_sink_pin),
    .led_drive_level(led_drive_level), .gpio_out(gpio_out));
  always #20 clk_sys = ~clk_sys;
  task automatic end_of_test();
    $display("Checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk("register", {8'h00, d & m}, {8'h00, e});
  endtask
  // Starts a burst, waits for busy to drop, compares edge counts on both outputs
  task automatic burst(input int led_e, input int gpio_e);
    logic [7:0] d;
    int n;
    int e0;
    int g0;
    e0 = u_irpe_led_rx.edges;
    g0 = u_irpe_led_rx.gedges;
    wr(8'hA9, 8'h02);
    rd(8'hA8, d);
    chk("busy", {15'h0000, d[0]}, 16'h0001);
    n = 0;
    while (d[0] !== 1'b0 && n < 20000) begin
      rd(8'hA8, d);
      n++;
    end
    chk("busy end", {15'h0000, d[0]}, 16'h0000);
    chk("led edges", 16'(u_irpe_led_rx.edges - e0), 16'(led_e));
    chk("gpio edges", 16'(u_irpe_led_rx.gedges - g0), 16'(gpio_e));
  endtask
  initial begin
    #2400000;
    num_errors++;
    end_of_test();
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    rstn = 1'b1;
    chk("int_n reset", {15'h0000, int_n}, 16'h0001);
    chk("oe reset", {14'h0000, gpio_oe, sensor_hold}, 16'h0000);
    rchk(8'h80, 8'hFF, 8'h00);
    // Durations 8 and 3 carrier periods, low byte first
    wr(8'h8D, 8'h01);
    wr(8'h00, 8'h08);
    wr(8'h01, 8'h00);
    wr(8'h02, 8'h03);
    wr(8'h03, 8'h00);
    rchk(8'h00, 8'hFF, 8'h08);
    rchk(8'h01, 8'hFF, 8'h00);
    wr(8'h8D, 8'h00);
    wr(8'h00, 8'h01);
    wr(8'h01, 8'hFF);
    wr(8'h02, 8'h01);
    rchk(8'h00, 8'hFF, 8'h01);
    wr(8'hA6, 8'h20);
    wr(8'h8F, 8'h15);
    wr(8'hA0, 8'h20);
    rchk(8'hA6, 8'hFF, 8'h20);
    wr(8'hA9, 8'h02);
    rchk(8'hA8, 8'h01, 8'h00);
    wr(8'h80, 8'h80);
    chk("sensor hold", {15'h0000, sensor_hold}, 16'h0001);
    burst(8, 0);
    chk("period", 16'(u_irpe_led_rx.period), 16'd200);
    chk("high 50", 16'(u_irpe_led_rx.high), 16'd100);
    chk("drive", {11'h000, u_irpe_led_rx.level}, 16'h0015);
    rchk(8'h93, 8'h08, 8'h08);
    rchk(8'hA8, 8'h02, 8'h02);
    chk("int pin", {15'h0000, int_n}, 16'h0000);
    wr(8'hDE, 8'h00);
    rchk(8'h93, 8'h08, 8'h00);
    chk("int pin clr", {15'h0000, int_n}, 16'h0001);
    wr(8'hA0, 8'h00);
    for (int d = 1; d < 4; d++) begin
      wr(8'hA1, 8'(d));
      burst(8, 0);
      chk("duty high", 16'(u_irpe_led_rx.high), 16'(100 - 25 * d));
    end
    chk("int masked", {15'h0000, int_n}, 16'h0001);
    wr(8'hA1, 8'h04);
    burst(1, 0);
    chk("dc high", 16'(u_irpe_led_rx.high), 16'd1599);
    // Zero gap: DC level carries straight into the next pulse
    wr(8'h8D, 8'h01);
    wr(8'h04, 8'h00);
    wr(8'h05, 8'h00);
    wr(8'h8D, 8'h00);
    wr(8'h00, 8'h02);
    wr(8'h01, 8'h01);
    wr(8'h02, 8'hFF);
    burst(1, 0);
    chk("zero carry", 16'(u_irpe_led_rx.high), 16'd3199);
    wr(8'h00, 8'h01);
    wr(8'h01, 8'hFF);
    wr(8'hA1, 8'h08);
    burst(0, 8);
    chk("gpio oe", {15'h0000, gpio_oe}, 16'h0001);
    wr(8'hA1, 8'h20);
    rchk(8'hA1, 8'hFF, 8'h20);
    chk("invert", {14'h0000, led_sink_pin, gpio_out}, 16'h0003);
    wr(8'hA1, 8'h00);
    wr(8'hA4, 8'h01);
    wr(8'hA5, 8'h01);
    burst(16, 0);
    // Repeat start at 3: pulses from bytes 0, 3, then 3 again
    wr(8'h01, 8'hFE);
    wr(8'h02, 8'h03);
    wr(8'h03, 8'h01);
    wr(8'h04, 8'hFF);
    wr(8'hA4, 8'h00);
    wr(8'hA2, 8'h01);
    burst(24, 0);
    wr(8'hDE, 8'h00);
    rchk(8'h93, 8'h08, 8'h00);
    wr(8'hA0, 8'h40);
    rchk(8'h93, 8'h08, 8'h08);
    chk("force pin", {15'h0000, int_n}, 16'h0000);
    wr(8'hA0, 8'h00);
    wr(8'hDE, 8'h00);
    rchk(8'hA8, 8'h02, 8'h00);
    wr(8'hA4, 8'hFF);
    wr(8'hA9, 8'h02);
    rchk(8'hA8, 8'h01, 8'h01);
    wr(8'h80, 8'h00);
    rchk(8'hA8, 8'h01, 8'h00);
    chk("sensor free", {15'h0000, sensor_hold}, 16'h0000);
    wr(8'h93, 8'hFF);
    rchk(8'h93, 8'hFF, 8'h00);
    rchk(8'hC0, 8'hFF, 8'h00);
    end_of_test();
  end
endmodule // tb_top
